// ==== rtl/channel_enable_control.sv ====
// channel enable register with master enable gating and pin masking
// assumes one-cycle wr/rd strobes on clk from the serial register front
// end; the enable pins are asynchronous and are filtered here
//
// Functional notes
// - Master enable low or power-on reset clears all channel bits.
// - Channels not in sequencer mode follow their own enable bit.
// - A write only lands while the master enable is high.
// - Master enable low turns manual channels off and clears their bits.
// - Bit 7 is a read-only flag, zero until data is valid, then one.
// - The flag reads one only after at least two reads; host retries.
// - Bits 0 to 6 enable channels 1 to 7, one on, zero off, reset zero.
// - Channel 4 bit is masked by the shared pin when its override is 0.
// - Channel 3 bit is masked by the shared pin when its override is 0.
// - Override zero lets the shared pin control, one removes the pin.
`timescale 1ns/10ps

module channel_enable_control
  import chan_enable_pkg::*;
(
  // clock and power-on reset
  input wire logic clk,
  input wire logic reset,
  // register port
  input wire reg_req_s req,
  output reg_rsp_s rsp,
  // device pins
  input wire logic master_en_pin,
  input wire logic chan34_enable_pin,
  // configuration from neighbouring registers
  input wire logic [6:0] seq_mode,
  input wire logic [6:0] seq_on,
  input wire logic chan4_pin_override,
  input wire logic chan3_pin_override,
  // regulator enables
  output logic [6:0] chan_on
);

  // ----------------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------------
  logic [1:0] pin_raw;
  logic [1:0] pin_f;
  logic en_f;
  logic pin34_f;

  assign pin_raw = {chan34_enable_pin, master_en_pin};

  // three stages, level taken only when stages two and three agree
  // per-pin locals keep each flop with a single driving process
  genvar p;
  generate
    for (p = 0; p < 2; p++) begin : g_sync
      logic [2:0] stage;
      logic level;
      always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
          stage <= SYNC_RESET;
          level <= 1'b0;
        end else begin
          stage <= {stage[1:0], pin_raw[p]};
          if (stage[1] == stage[2]) begin
            level <= stage[2];
          end
        end
      end
      assign pin_f[p] = level;
    end
  endgenerate

  assign en_f = pin_f[0];
  assign pin34_f = pin_f[1];

  // ----------------------------------------------------------------------
  // register decode
  // ----------------------------------------------------------------------
  logic hit;
  logic wr_hit;
  logic rd_hit;
  logic [6:0] manual;
  logic [6:0] next_manual;
  logic [1:0] read_count;
  logic [1:0] next_read_count;
  logic read_valid_flag;
  logic [7:0] read_word;

  assign hit = (req.addr == CHANNEL_ENABLE_REGISTER_ADDR);
  assign wr_hit = req.wr & hit;
  assign rd_hit = req.rd & hit;

  // enable low wins over any write in the same cycle
  assign next_manual = !en_f ? CHAN_ON_RESET :
                       wr_hit ? req.wdata[6:0] :
                       manual;

  // a write restarts the valid count so stale data is never flagged
  assign next_read_count = (!en_f || wr_hit) ? READ_COUNT_RESET :
                           (rd_hit && read_count != READS_NEEDED) ?
                           read_count + 2'h1 : read_count;

  assign read_valid_flag = en_f && (read_count == READS_NEEDED);
  assign read_word = {read_valid_flag, manual};

  // channel bits and read counter
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      manual <= CHAN_ON_RESET;
      read_count <= READ_COUNT_RESET;
    end else begin
      manual <= next_manual;
      read_count <= next_read_count;
    end
  end

  // read answer one cycle after the strobe; unmapped reads return zero
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      rsp.rvalid <= 1'b0;
      rsp.rdata <= READ_DATA_RESET;
    end else begin
      rsp.rvalid <= req.rd;
      if (rd_hit) begin
        rsp.rdata <= read_word;
      end else if (req.rd) begin
        rsp.rdata <= UNMAPPED_READ;
      end
    end
  end

  // ----------------------------------------------------------------------
  // channel drive
  // ----------------------------------------------------------------------
  logic [6:0] pin_gate;
  logic [6:0] next_chan_on;

  // shared pin only gates channels 3 and 4, and only without override
  genvar c;
  generate
    for (c = 0; c < CHAN_COUNT; c++) begin : g_chan
      if (c == CHAN4_BIT) begin : g_c4
        assign pin_gate[c] = chan4_pin_override | pin34_f;
      end else if (c == CHAN3_BIT) begin : g_c3
        assign pin_gate[c] = chan3_pin_override | pin34_f;
      end else begin : g_plain
        assign pin_gate[c] = 1'b1;
      end
      // sequencer channels ignore the manual bit entirely
      assign next_chan_on[c] = seq_mode[c] ? seq_on[c] :
                               (manual[c] & en_f & pin_gate[c]);
    end
  endgenerate

  // registered so the regulators never see decode glitches
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      chan_on <= CHAN_ON_RESET;
    end else begin
      chan_on <= next_chan_on;
    end
  end

  // ----------------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------------
  // checks look one edge ahead, matching the registered outputs
  AST_EN_LOW_CLEARS: assert property (
    @(posedge clk) disable iff (reset)
    !en_f |=> manual == CHAN_ON_RESET)
    else $error("channel bits not cleared with enable low");

  AST_MANUAL_FOLLOWS: assert property (
    @(posedge clk) disable iff (reset)
    (!seq_mode[0] && en_f) |=> chan_on[0] == $past(manual[0]))
    else $error("manual channel 1 does not follow its bit");

  AST_SEQ_FOLLOWS: assert property (
    @(posedge clk) disable iff (reset)
    seq_mode[6] |=> chan_on[6] == $past(seq_on[6]))
    else $error("sequencer channel 7 overridden by manual bit");

  AST_WRITE_BLOCKED: assert property (
    @(posedge clk) disable iff (reset)
    (wr_hit && !en_f) |=> manual == CHAN_ON_RESET)
    else $error("write landed with enable low");

  AST_WRITE_LANDS: assert property (
    @(posedge clk) disable iff (reset)
    (wr_hit && en_f) |=> manual == $past(req.wdata[6:0]))
    else $error("write with enable high not stored");

  AST_OFF_ON_EN_LOW: assert property (
    @(posedge clk) disable iff (reset)
    (!en_f && seq_mode == 7'h00) |=> chan_on == 7'h00)
    else $error("manual channels still on with enable low");

  // the count restarts on a write, so a stale word is never flagged
  AST_WRITE_RESTARTS: assert property (
    @(posedge clk) disable iff (reset)
    wr_hit |=> read_count == READ_COUNT_RESET)
    else $error("read count not restarted by write");

  AST_FLAG_NEEDS_TWO: assert property (
    @(posedge clk) disable iff (reset)
    (rd_hit && read_count != READS_NEEDED) |=> !rsp.rdata[READ_VALID_BIT])
    else $error("flag set before two reads");

  AST_FLAG_AFTER_TWO: assert property (
    @(posedge clk) disable iff (reset)
    (rd_hit && en_f && read_count == READS_NEEDED) |=>
    rsp.rdata[READ_VALID_BIT])
    else $error("flag not set after two reads");

  AST_FLAG_LOW_EN: assert property (
    @(posedge clk) disable iff (reset)
    (rd_hit && !en_f) |=> !rsp.rdata[READ_VALID_BIT])
    else $error("flag set while enable low");

  AST_CH4_MASK: assert property (
    @(posedge clk) disable iff (reset)
    (!seq_mode[CHAN4_BIT] && !chan4_pin_override && !pin34_f) |=>
    !chan_on[CHAN4_BIT])
    else $error("channel 4 not masked by shared pin");

  AST_CH4_FREE: assert property (
    @(posedge clk) disable iff (reset)
    (!seq_mode[CHAN4_BIT] && chan4_pin_override && en_f) |=>
    chan_on[CHAN4_BIT] == $past(manual[CHAN4_BIT]))
    else $error("channel 4 masked despite override");

  AST_CH3_MASK: assert property (
    @(posedge clk) disable iff (reset)
    (!seq_mode[CHAN3_BIT] && !chan3_pin_override && !pin34_f) |=>
    !chan_on[CHAN3_BIT])
    else $error("channel 3 not masked by shared pin");

  AST_CH3_FREE: assert property (
    @(posedge clk) disable iff (reset)
    (!seq_mode[CHAN3_BIT] && chan3_pin_override && en_f) |=>
    chan_on[CHAN3_BIT] == $past(manual[CHAN3_BIT]))
    else $error("channel 3 masked despite override");

endmodule

// ==== rtl/chan_enable_pkg.sv ====
// constants and carrier types for the channel enable register block
// assumes the register port is fed by an already decoded serial front end
package chan_enable_pkg;

  // ----------------------------------------------------------------------
  // register map and field layout
  // ----------------------------------------------------------------------
  localparam logic [7:0] CHANNEL_ENABLE_REGISTER_ADDR = 8'h30;
  localparam int CHAN_COUNT = 7;
  localparam int READ_VALID_BIT = 7;
  localparam int CHAN3_BIT = 2;
  localparam int CHAN4_BIT = 3;
  localparam logic [6:0] CHAN_ON_RESET = 7'h00;
  localparam logic [7:0] READ_DATA_RESET = 8'h00;
  localparam logic [7:0] UNMAPPED_READ = 8'h00;

  // ----------------------------------------------------------------------
  // read valid counting and pin filtering
  // ----------------------------------------------------------------------
  localparam logic [1:0] READS_NEEDED = 2'h2;
  localparam logic [1:0] READ_COUNT_RESET = 2'h0;
  localparam logic [2:0] SYNC_RESET = 3'h0;

  // ----------------------------------------------------------------------
  // register port carriers
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_req_s;

  typedef struct packed {
    logic rvalid;
    logic [7:0] rdata;
  } reg_rsp_s;

endpackage

// ==== test/host_model.sv ====
// host side model: issues one-cycle register strobes
// assumes rvalid comes one cycle after the read strobe edge
`timescale 1ns/10ps

module host_model
  import chan_enable_pkg::*;
(
  // clock
  input wire logic clk,
  // register port
  output reg_req_s req,
  input wire reg_rsp_s rsp
);
  initial req = '0;

  // write strobe; released address is inverted so stale values show
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge clk);
    req.wr <= 1'b0;
    req.addr <= ~a;
    @(posedge clk);
  endtask

  // read strobe; data only trusted with rvalid
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: ~req.wdata};
    @(posedge clk);
    req.rd <= 1'b0;
    req.addr <= ~a;
    @(posedge clk);
    d = rsp.rvalid ? rsp.rdata : ~rsp.rdata;
  endtask
endmodule

// ==== test/channel_enable_control_tb.sv ====
// self-checking bench for the channel enable register
// assumes host_model drives the register port
`timescale 1ns/10ps

module channel_enable_control_tb
  import chan_enable_pkg::*;
;
  logic clk = 0, reset = 1, en = 0, pin = 0, o3 = 0, o4 = 0;
  logic [6:0] sm = '0, so = '0, chan_on, mbits;
  logic [31:0] seed = 32'h9d308694;
  reg_req_s req;
  reg_rsp_s rsp;
  int errors = 0, num_checks = 0, cyc = 0, rcnt = 0;

  always #2.5 clk = ~clk;
  host_model i_host (.clk(clk), .req(req), .rsp(rsp));
  channel_enable_control i_dut (.clk(clk), .reset(reset), .req(req),
    .rsp(rsp), .master_en_pin(en), .chan34_enable_pin(pin),
    .seq_mode(sm), .seq_on(so), .chan4_pin_override(o4),
    .chan3_pin_override(o3), .chan_on(chan_on));

  // ----------------------------------------------------------------
  // model and checking helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  // manual channels gated by enable and shared pin
  function automatic logic [7:0] exp_on();
    logic [6:0] g;
    g = 7'h7f;
    g[2] = o3 | pin;
    g[3] = o4 | pin;
    return {1'b0, (sm & so) | (~sm & mbits & g & {7{en}})};
  endfunction

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic print_verdict();
    $display("checks=%0d errors=%0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // flag counts completed reads since last write or enable rise
  task automatic rd_chk();
    logic [7:0] d;
    i_host.rd(8'h30, d);
    chk(d, {rcnt >= 2 && en, mbits});
    // reads with enable low do not count towards the valid flag
    if (!en) begin
      rcnt = 0;
    end else if (rcnt < 2) begin
      rcnt++;
    end
  endtask

  task automatic wr_m(input logic [7:0] d);
    i_host.wr(8'h30, d);
    mbits = en ? d[6:0] : 7'h00;
    rcnt = 0;
  endtask

  // hang guard
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      errors++;
      print_verdict();
    end
  end

  initial begin
    logic [7:0] d;
    logic [31:0] r;
    mbits = 7'h00;
    repeat (20) @(posedge clk);
    reset <= 0;
    @(posedge clk);
    rd_chk();
    wr_m(8'h7f);
    rd_chk();
    en <= 1;
    repeat (8) @(posedge clk);
    for (int i = 0; i < 8; i++) begin
      r = rnd();
      sm <= r[14:8] & r[22:16];
      so <= r[30:24];
      {o3, o4, pin} <= r[2:0];
      r = rnd();
      wr_m(r[7:0]);
      repeat (8) @(posedge clk);
      chk({1'b0, chan_on}, exp_on());
      repeat (3) rd_chk();
    end
    i_host.rd(8'h31, d);
    chk(d, 8'h00);
    sm <= 7'h00;
    wr_m(8'h7f);
    // channels must be on before enable drops, or the next check is idle
    repeat (2) @(posedge clk);
    chk({1'b0, chan_on}, exp_on());
    en <= 0;
    repeat (8) @(posedge clk);
    mbits = 7'h00;
    rcnt = 0;
    chk({1'b0, chan_on}, exp_on());
    rd_chk();
    en <= 1;
    repeat (8) @(posedge clk);
    repeat (3) rd_chk();
    wr_m(8'h55);
    reset <= 1;
    @(posedge clk);
    reset <= 0;
    mbits = 7'h00;
    rcnt = 0;
    repeat (8) @(posedge clk);
    chk({1'b0, chan_on}, 8'h00);
    repeat (3) rd_chk();
    print_verdict();
  end
endmodule
